/* File: shared/tdw_map.svh */
// descriptor layout, register offsets and control bits of the descriptor walker
`ifndef TDW_MAP_SVH
`define TDW_MAP_SVH
// descriptor word offsets from the descriptor base address
`define TDW_OFS_LINK 32'h0000_0000
`define TDW_OFS_BUF 32'h0000_0004
`define TDW_OFS_LEN 32'h0000_0008
`define TDW_OFS_FLG 32'h0000_000C
// halfword split of the third and fourth words
`define TDW_HI_HALF 31:16
`define TDW_LO_HALF 15:0
// flag positions in the fourth word, from bit 31 downward
`define TDW_BIT_FIRST 31
`define TDW_BIT_LAST 30
`define TDW_BIT_HELD 29
`define TDW_BIT_QEND 28
`define TDW_BIT_ABORT 27
`define TDW_BIT_FCS 26
// apb register offsets
`define TDW_REG_CTRL 8'h00
`define TDW_REG_HEAD 8'h04
`define TDW_REG_STATUS 8'h08
`define TDW_REG_CUR 8'h0C
`define TDW_REG_PKTLEN 8'h10
// control register bits, write one to act
`define TDW_CTL_START 0
`define TDW_CTL_ABORT 1
// status register bits
`define TDW_STA_BUSY 0
`define TDW_STA_HALT 1
`define TDW_STA_ABORT 2
`define TDW_STA_UNOWNED 3
// reset values
`define TDW_HEAD_RST 32'h0000_0000
`define TDW_WORD_RST 32'h0000_0000
`endif

/* File: shared/tdw_pkg.sv */
// types shared by the descriptor walker and its testbench
package tdw_pkg;
    // walker sequence states
    typedef enum logic [3:0] {
        S_IDLE, S_RD_BUF, S_RD_LEN, S_RD_FLG, S_CHECK, S_DATA_RD,
        S_DATA_PUSH, S_RD_LINK, S_WB_EOP, S_WB_SOP, S_WB_ABORT
    } tdw_state_t;
    // one streamed byte with its packet markers
    typedef struct packed {
        logic no_fcs;
        logic first;
        logic last;
        logic [7:0] data;
    } tdw_beat_t;
endpackage

/* File: core/tdw_fifo.sv */
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module tdw_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 2
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_reg [DEPTH]; // storage, depth must be a power of two
    logic [PW-1:0] wr_ptr_reg; // next slot to fill
    logic [PW-1:0] rd_ptr_reg; // oldest slot
    logic [CW-1:0] count_reg; // words held
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;

    assign in_ready = count_reg != CW'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data = mem_reg[rd_ptr_reg];

    // write side fills storage
    always_ff @(posedge clock)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data;
    end

    // pointers and fill count
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + PW'(1);
            if (push && !pop)
                count_reg <= count_reg + CW'(1);
            else if (pop && !push)
                count_reg <= count_reg - CW'(1);
        end
    end
endmodule

/* File: core/tdw_walker.sv */
// transmit descriptor walker: fetches descriptors, streams bytes, writes status back
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tdw_map.svh"
module tdw_walker
    import tdw_pkg::*;
#(
    parameter int BUF_DEPTH = 2
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic tx_valid,
    input wire logic tx_ready,
    output tdw_beat_t tx_beat,
    output logic [15:0] tx_pkt_len
);
    tdw_state_t state_reg, state_next; // walker state
    logic [31:0] addr_reg, addr_next; // memory address for the current access
    logic [31:0] desc_reg; // current descriptor base
    logic [31:0] sop_reg; // first descriptor of the packet
    logic [31:0] buf_reg; // buffer address word
    logic [31:0] flg_reg; // fourth word of the current descriptor
    logic [31:0] sop_flg_reg; // fourth word of the first descriptor
    logic [31:0] link_reg; // link word read last
    logic [31:0] ptr_reg; // byte pointer into the buffer
    logic [31:0] head_reg; // software start address
    logic [31:0] prdata_reg; // read data captured in setup phase
    logic [15:0] off_reg; // buffer offset field
    logic [15:0] rem_reg; // bytes left in this buffer
    logic [15:0] pkt_len_reg; // packet length from the first descriptor
    logic [7:0] byte_reg; // byte waiting to be pushed
    logic fcs_reg; // fcs supplied by software for this packet
    logic first_reg; // next byte opens the packet
    logic in_pkt_reg; // inside a packet, continuations allowed
    logic eoq_hit_reg; // last descriptor had a zero link
    logic abort_pend_reg; // teardown requested
    logic halt_reg; // channel halted on zero link or stray continuation
    logic abort_done_reg; // teardown finished
    logic unowned_reg; // first descriptor not held by engine
    tdw_beat_t beat_in; // byte entering the buffer
    logic [10:0] beat_out; // raw buffer output
    logic push_ready; // buffer can take a byte

    // pick one byte lane of a word, lane 0 is bits 7:0
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] lane);
        byte_of = w[8*lane +: 8];
    endfunction

    // word address holding a byte address
    function automatic logic [31:0] word_of(input logic [31:0] a);
        word_of = {a[31:2], 2'b00};
    endfunction

    // apb decode
    wire logic apb_wr = psel && penable && pwrite;
    wire logic apb_setup = psel && !penable;
    wire logic sel_ctrl = paddr == `TDW_REG_CTRL;
    wire logic sel_head = paddr == `TDW_REG_HEAD;
    wire logic sel_stat = paddr == `TDW_REG_STATUS;
    wire logic sel_cur = paddr == `TDW_REG_CUR;
    wire logic sel_len = paddr == `TDW_REG_PKTLEN;
    wire logic sel_hit = sel_ctrl || sel_head || sel_stat || sel_cur || sel_len;
    wire logic idle = state_reg == S_IDLE;
    wire logic start_cmd = apb_wr && sel_ctrl && pwdata[`TDW_CTL_START];
    wire logic abort_cmd = apb_wr && sel_ctrl && pwdata[`TDW_CTL_ABORT];
    wire logic start_go = start_cmd && idle && !abort_pend_reg && head_reg != `TDW_WORD_RST;
    wire logic [31:0] status_word = ({31'h0, !idle} << `TDW_STA_BUSY) | ({31'h0, halt_reg} << `TDW_STA_HALT)
        | ({31'h0, abort_done_reg} << `TDW_STA_ABORT) | ({31'h0, unowned_reg} << `TDW_STA_UNOWNED);
    wire logic [31:0] rd_word = sel_head ? head_reg : sel_stat ? status_word : sel_cur ? desc_reg
        : sel_len ? {16'h0000, pkt_len_reg} : `TDW_WORD_RST;

    // flags of the current descriptor
    wire logic cur_first = flg_reg[`TDW_BIT_FIRST];
    wire logic cur_last = flg_reg[`TDW_BIT_LAST];
    wire logic cur_held = flg_reg[`TDW_BIT_HELD];
    wire logic link_zero = mem_rdata == `TDW_WORD_RST;
    wire logic last_byte = rem_reg == 16'h0001;
    wire logic fetch_ack = mem_ack && mem_req;
    // offset skipped only on the first buffer
    wire logic [31:0] start_ptr = cur_first ? buf_reg + {16'h0000, off_reg} : buf_reg;
    wire logic do_abort = cur_first && abort_pend_reg;
    wire logic bad_held_by_engine_flag = cur_first && !cur_held && !abort_pend_reg;
    wire logic bad_cont = !cur_first && !in_pkt_reg;
    wire logic push_valid = state_reg == S_DATA_PUSH;
    wire logic push_done = push_valid && push_ready;

    // write-back words keep every field except the engine flags
    wire logic [31:0] held_clr = ~(32'h1 << `TDW_BIT_HELD);
    wire logic [31:0] qend_bit = 32'h1 << `TDW_BIT_QEND;
    wire logic [31:0] eop_word = flg_reg | qend_bit;
    wire logic [31:0] sop_qend = (eoq_hit_reg && desc_reg == sop_reg) ? qend_bit : `TDW_WORD_RST;
    wire logic [31:0] sop_word = (sop_flg_reg & held_clr) | sop_qend;
    wire logic [31:0] abort_word = (flg_reg & held_clr) | (32'h1 << `TDW_BIT_ABORT);

    // bus master outputs, writes touch only the fourth word
    assign mem_req = !(idle || state_reg == S_CHECK || push_valid);
    assign mem_we = state_reg == S_WB_EOP || state_reg == S_WB_SOP || state_reg == S_WB_ABORT;
    assign mem_addr = addr_reg;
    assign mem_wdata = state_reg == S_WB_EOP ? eop_word : state_reg == S_WB_SOP ? sop_word : abort_word;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !sel_hit;
    assign prdata = prdata_reg;
    assign tx_pkt_len = pkt_len_reg;
    assign tx_beat = tdw_beat_t'(beat_out);
    // byte markers, fcs choice travels with every byte
    assign beat_in = '{no_fcs: fcs_reg, first: first_reg, last: cur_last && last_byte, data: byte_reg};

    // next state and next memory address
    always_comb
    begin
        state_next = state_reg;
        addr_next = addr_reg;
        case (state_reg)
            S_IDLE:
            begin
                if (start_go)
                begin
                    state_next = S_RD_BUF;
                    addr_next = head_reg + `TDW_OFS_BUF;
                end
            end
            S_RD_BUF:
            begin
                if (fetch_ack)
                begin
                    state_next = S_RD_LEN;
                    addr_next = desc_reg + `TDW_OFS_LEN;
                end
            end
            S_RD_LEN:
            begin
                if (fetch_ack)
                begin
                    state_next = S_RD_FLG;
                    addr_next = desc_reg + `TDW_OFS_FLG;
                end
            end
            S_RD_FLG:
            begin
                if (fetch_ack)
                    state_next = S_CHECK;
            end
            S_CHECK:
            begin
                if (do_abort)
                begin
                    state_next = S_WB_ABORT;
                    addr_next = desc_reg + `TDW_OFS_FLG;
                end
                else if (bad_held_by_engine_flag || bad_cont)
                    state_next = S_IDLE;
                else if (rem_reg == 16'h0000)
                begin
                    state_next = S_RD_LINK;
                    addr_next = desc_reg + `TDW_OFS_LINK;
                end
                else
                begin
                    state_next = S_DATA_RD;
                    addr_next = word_of(start_ptr);
                end
            end
            S_DATA_RD:
            begin
                if (fetch_ack)
                    state_next = S_DATA_PUSH;
            end
            S_DATA_PUSH:
            begin
                if (push_ready && last_byte)
                begin
                    state_next = S_RD_LINK; // link read after the data
                    addr_next = desc_reg + `TDW_OFS_LINK;
                end
                else if (push_ready)
                begin
                    state_next = S_DATA_RD;
                    addr_next = word_of(ptr_reg + 32'h0000_0001);
                end
            end
            S_RD_LINK:
            begin
                if (fetch_ack && cur_last)
                begin
                    state_next = (link_zero && desc_reg != sop_reg) ? S_WB_EOP : S_WB_SOP;
                    addr_next = (link_zero && desc_reg != sop_reg) ? desc_reg + `TDW_OFS_FLG
                        : sop_reg + `TDW_OFS_FLG;
                end
                else if (fetch_ack && link_zero)
                    state_next = S_IDLE;
                else if (fetch_ack)
                begin
                    state_next = S_RD_BUF;
                    addr_next = mem_rdata + `TDW_OFS_BUF;
                end
            end
            S_WB_EOP:
            begin
                if (fetch_ack)
                begin
                    state_next = S_WB_SOP;
                    addr_next = sop_reg + `TDW_OFS_FLG;
                end
            end
            S_WB_SOP:
            begin
                if (fetch_ack && link_reg == `TDW_WORD_RST)
                    state_next = S_IDLE;
                else if (fetch_ack)
                begin
                    state_next = S_RD_BUF;
                    addr_next = link_reg + `TDW_OFS_BUF;
                end
            end
            S_WB_ABORT:
            begin
                if (fetch_ack)
                    state_next = S_IDLE; // nothing later is touched
            end
            default:
                state_next = S_IDLE;
        endcase
    end

    // state and address registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= S_IDLE;
            addr_reg <= `TDW_WORD_RST;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg <= addr_next;
        end
    end

    // descriptor fields captured as they arrive
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            buf_reg <= `TDW_WORD_RST;
            off_reg <= 16'h0000;
            flg_reg <= `TDW_WORD_RST;
            byte_reg <= 8'h00;
        end
        else
        begin
            if (state_reg == S_RD_BUF && fetch_ack)
                buf_reg <= mem_rdata;
            if (state_reg == S_RD_FLG && fetch_ack)
                flg_reg <= mem_rdata;
            if (state_reg == S_RD_LEN && fetch_ack)
                off_reg <= mem_rdata[`TDW_HI_HALF];
            if (state_reg == S_DATA_RD && fetch_ack)
                byte_reg <= byte_of(mem_rdata, ptr_reg[1:0]);
        end
    end

    // buffer walk: pointer and remaining count
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ptr_reg <= `TDW_WORD_RST;
            rem_reg <= 16'h0000;
            first_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == S_RD_LEN && fetch_ack)
                rem_reg <= mem_rdata[`TDW_LO_HALF]; // valid bytes only
            else if (push_done)
                rem_reg <= rem_reg - 16'h0001;
            if (state_reg == S_CHECK)
                ptr_reg <= start_ptr;
            else if (push_done)
                ptr_reg <= ptr_reg + 32'h0000_0001;
            if (state_reg == S_CHECK && cur_first)
                first_reg <= 1'b1;
            else if (push_done)
                first_reg <= 1'b0;
        end
    end

    // packet context taken from the first descriptor only
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sop_reg <= `TDW_WORD_RST;
            sop_flg_reg <= `TDW_WORD_RST;
            pkt_len_reg <= 16'h0000;
            fcs_reg <= 1'b0;
        end
        else if (state_reg == S_CHECK && cur_first && cur_held && !abort_pend_reg)
        begin
            sop_reg <= desc_reg;
            sop_flg_reg <= flg_reg;
            pkt_len_reg <= flg_reg[`TDW_LO_HALF];
            fcs_reg <= flg_reg[`TDW_BIT_FCS];
        end
    end

    // list position and link handling
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            desc_reg <= `TDW_WORD_RST;
            link_reg <= `TDW_WORD_RST;
            eoq_hit_reg <= 1'b0;
            in_pkt_reg <= 1'b0;
        end
        else
        begin
            if (start_go)
                desc_reg <= head_reg;
            else if (state_reg == S_RD_LINK && fetch_ack && !cur_last && !link_zero)
                desc_reg <= mem_rdata;
            else if (state_reg == S_WB_SOP && fetch_ack && link_reg != `TDW_WORD_RST)
                desc_reg <= link_reg;
            if (state_reg == S_RD_LINK && fetch_ack)
            begin
                link_reg <= mem_rdata;
                eoq_hit_reg <= cur_last && link_zero;
            end
            if (state_reg == S_CHECK && cur_first && cur_held && !abort_pend_reg)
                in_pkt_reg <= 1'b1;
            else if (start_go || state_next == S_IDLE || (state_reg == S_WB_SOP && fetch_ack))
                in_pkt_reg <= 1'b0;
        end
    end

    // software registers and status; a hardware set wins over a start clear
    wire logic halt_set = (state_reg == S_RD_LINK && fetch_ack && !cur_last && link_zero)
        || (state_reg == S_WB_SOP && fetch_ack && link_reg == `TDW_WORD_RST)
        || (state_reg == S_CHECK && bad_cont && !do_abort);
    wire logic abort_set = (state_reg == S_WB_ABORT && fetch_ack) || (idle && abort_pend_reg);
    wire logic unowned_set = state_reg == S_CHECK && bad_held_by_engine_flag;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            head_reg <= `TDW_HEAD_RST;
            prdata_reg <= `TDW_WORD_RST;
            abort_pend_reg <= 1'b0;
            halt_reg <= 1'b0;
            abort_done_reg <= 1'b0;
            unowned_reg <= 1'b0;
        end
        else
        begin
            if (apb_wr && sel_head)
                head_reg <= {pwdata[31:2], 2'b00};
            if (apb_setup && !pwrite)
                prdata_reg <= rd_word;
            abort_pend_reg <= abort_cmd || (abort_pend_reg && !abort_set);
            halt_reg <= halt_set || (halt_reg && !start_cmd);
            abort_done_reg <= abort_set || (abort_done_reg && !start_cmd);
            unowned_reg <= unowned_set || (unowned_reg && !start_cmd);
        end
    end

    // buffer of BUF_DEPTH entries, two by default, between the walker and the transmitter
    tdw_fifo #(
        .WIDTH($bits(tdw_beat_t)),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(beat_in),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(beat_out)
    );

    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    desc_align_a: assert property (mem_req && !(state_reg == S_DATA_RD) |-> mem_addr[1:0] == 2'b00)
        else $error("descriptor access not word aligned");
    only_flags_a: assert property (mem_req && mem_we |-> mem_addr == desc_reg + `TDW_OFS_FLG
        || mem_addr == sop_reg + `TDW_OFS_FLG)
        else $error("engine wrote a word other than the flags word");
    held_clear_a: assert property (state_reg == S_WB_SOP && mem_req |-> !mem_wdata[`TDW_BIT_HELD])
        else $error("held flag not cleared on first descriptor");
    markers_kept_a: assert property (state_reg == S_WB_EOP && mem_req |->
        mem_wdata[31:30] == flg_reg[31:30] && mem_wdata[`TDW_BIT_QEND])
        else $error("write back changed markers or missed queue end");
    zero_link_a: assert property (state_reg == S_RD_LINK && fetch_ack && link_zero |=>
        state_reg != S_RD_BUF ##1 state_reg != S_RD_BUF)
        else $error("engine followed a zero link");
    follow_link_a: assert property (state_reg == S_RD_LINK && fetch_ack && !link_zero && !cur_last |=>
        state_reg == S_RD_BUF && mem_addr == $past(mem_rdata) + `TDW_OFS_BUF)
        else $error("next descriptor not fetched from link");
    offset_use_a: assert property (state_reg == S_CHECK && !do_abort && !bad_held_by_engine_flag && !bad_cont |=>
        ptr_reg == $past(cur_first ? buf_reg + {16'h0000, off_reg} : buf_reg))
        else $error("buffer offset applied wrongly");
    len_hold_a: assert property (state_reg == S_RD_FLG && fetch_ack && !mem_rdata[`TDW_BIT_FIRST] |=>
        ##1 $stable(pkt_len_reg))
        else $error("packet length taken from continuation");
    abort_stop_a: assert property (state_reg == S_WB_ABORT && fetch_ack |=> idle [*2])
        else $error("engine continued after teardown");
    fcs_tag_a: assert property (push_done |-> beat_in.no_fcs == sop_flg_reg[`TDW_BIT_FCS]
        && (!beat_in.last || (flg_reg[`TDW_BIT_LAST] && rem_reg == 16'h0001)))
        else $error("byte markers wrong");
endmodule

/* File: verif/tdw_mem_model.sv */
// memory partner: descriptor and buffer store behind the walker's bus master
`timescale 1ns/1ps
module tdw_mem_model (
    input wire logic clock,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] slow,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    // word store; software fills and links aligned four-word descriptors
    logic [31:0] mem [0:127];
    logic [3:0] cnt_reg; // idle cycles before the answer
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
        cnt_reg = 4'h0;
    end
    // one-cycle ack after slow waits; outside ack the data lines invert
    always @(posedge clock)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_ack && mem_we)
            mem[mem_addr[8:2]] <= mem_wdata;
        if (mem_req && !mem_ack)
        begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg >= slow)
            begin
                cnt_reg <= 4'h0;
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr[8:2]];
            end
        end
    end
endmodule

/* File: verif/tdw_walker_tb.sv */
// self-checking bench of the descriptor walker
`timescale 1ns/1ps
`include "tdw_map.svh"
module tdw_walker_tb
    import tdw_pkg::*;
;
    typedef struct {logic [31:0] b; logic [15:0] off; logic [15:0] len; logic fcs; logic [3:0] slow;} tdwtb_row_t;
    localparam logic [31:0] m_fi = 32'h1 << `TDW_BIT_FIRST;
    localparam logic [31:0] m_la = 32'h1 << `TDW_BIT_LAST;
    localparam logic [31:0] m_he = 32'h1 << `TDW_BIT_HELD;
    localparam logic [31:0] m_qe = 32'h1 << `TDW_BIT_QEND;
    localparam logic [31:0] m_ab = 32'h1 << `TDW_BIT_ABORT;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, tx_valid, tx_ready, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd, f;
    logic [15:0] tx_pkt_len;
    logic [3:0] slow;
    tdw_beat_t tx_beat;
    tdw_beat_t got [$]; // accepted stream beats
    int n_fail, checks, cyc;
    // single-fragment packets: offset boundary, fcs supplied, slow memory
    tdwtb_row_t rows [3] = '{'{32'h11, 16'h0, 16'h1, 1'b0, 4'h0},
        '{32'h20, 16'h000F, 16'h3, 1'b1, 4'h2}, '{32'h3, 16'h2, 16'h5, 1'b0, 4'h1}};
    tdw_walker u_tdw_walker (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat), .tx_pkt_len(tx_pkt_len));
    tdw_mem_model u_tdw_mem_model (.clock(clock), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always #5 clock = ~clock;
    // sink stalls half of every eight cycles; hang guard
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        tx_ready <= cyc[2];
        if (tx_valid && tx_ready)
            got.push_back(tx_beat);
        if (cyc > 20000)
        begin
            n_fail++;
            tally_and_finish;
        end
    end
    task chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer, result taken at the ready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task desc(input int i, input logic [31:0] l, input logic [31:0] b, input logic [31:0] o, input logic [31:0] g);
        {u_tdw_mem_model.mem[i], u_tdw_mem_model.mem[i+1]} = {l, b};
        {u_tdw_mem_model.mem[i+2], u_tdw_mem_model.mem[i+3]} = {o, g};
    endtask
    task go(input logic [31:0] h);
        apb(1'b1, `TDW_REG_HEAD, h);
        apb(1'b1, `TDW_REG_CTRL, 32'h1);
    endtask
    // poll busy, then let the buffer drain
    task fin;
        int k;
        k = 0;
        do begin apb(1'b0, `TDW_REG_STATUS, 32'h0); k++; end while (rd[`TDW_STA_BUSY] !== 1'b0 && k < 500);
        k = 0;
        while (tx_valid !== 1'b0 && k < 100) begin @(posedge clock); k++; end
        chk(rd[`TDW_STA_BUSY], 32'h0);
    endtask
    // byte at address a holds a[7:0]
    task pkt(input logic [31:0] a0, input int n0, input logic [31:0] a1, input int n1, input logic fc);
        logic [31:0] a;
        chk(got.size(), n0 + n1);
        for (int i = 0; i < got.size() && i < n0 + n1; i++)
        begin
            a = (i < n0) ? a0 + i : a1 + i - n0;
            chk({got[i].no_fcs, got[i].first, got[i].last, got[i].data}, {fc, i == 0, i == n0 + n1 - 1, a[7:0]});
        end
        got.delete();
    endtask
    task tally_and_finish;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        {clock, rst_b, psel, penable, pwrite, tx_ready, paddr, pwdata, slow, n_fail, checks, cyc} = '0;
        for (int i = 0; i < 64; i++)
            u_tdw_mem_model.mem[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, `TDW_REG_STATUS, 32'h0);
        chk({rd, tx_valid, tx_pkt_len}, 64'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int r = 0; r < 3; r++)
        begin
            slow <= rows[r].slow;
            f = m_fi | m_la | m_he | (32'(rows[r].fcs) << `TDW_BIT_FCS) | 32'(rows[r].len);
            desc(64, 32'h0, rows[r].b, {rows[r].off, rows[r].len}, f);
            go(32'h100);
            fin;
            pkt(rows[r].b + rows[r].off, rows[r].len, 0, 0, rows[r].fcs);
            chk(u_tdw_mem_model.mem[67], f ^ m_he ^ m_qe);
            chk({u_tdw_mem_model.mem[64], u_tdw_mem_model.mem[66]}, {32'h0, rows[r].off, rows[r].len});
            chk({tx_pkt_len, rd[`TDW_STA_HALT]}, {rows[r].len, 1'b1});
        end
        // two fragments: second offset and packet length field ignored
        desc(64, 32'h110, 32'h40, {16'h4, 16'h2}, m_fi | m_he | 32'h5);
        desc(68, 32'h0, 32'h80, {16'h7, 16'h3}, m_la | 32'h9);
        go(32'h100);
        fin;
        pkt(32'h44, 2, 32'h80, 3, 1'b0);
        chk(tx_pkt_len, 32'h5);
        chk(u_tdw_mem_model.mem[67], m_fi | 32'h5);
        chk(u_tdw_mem_model.mem[71], m_la | m_qe | 32'h9);
        apb(1'b0, `TDW_REG_PKTLEN, 32'h0);
        chk(rd, 64'h5);
        apb(1'b0, `TDW_REG_CUR, 32'h0);
        chk(rd, 64'h110);
        // teardown while the first descriptor is being fetched
        slow <= 4'h3;
        desc(72, 32'h130, 32'h0, 32'h1, m_fi | m_la | m_he | 32'h1);
        desc(76, 32'h0, 32'h0, 32'h1, m_fi | m_la | m_he | 32'h1);
        go(32'h120);
        apb(1'b1, `TDW_REG_CTRL, 32'h2);
        fin;
        pkt(0, 0, 0, 0, 1'b0);
        chk(u_tdw_mem_model.mem[75], m_fi | m_la | m_ab | 32'h1);
        chk({u_tdw_mem_model.mem[79], rd[`TDW_STA_ABORT]}, {m_fi | m_la | m_he | 32'h1, 1'b1});
        // first descriptor no longer held: stop, stream nothing, write nothing
        go(32'h100);
        fin;
        pkt(0, 0, 0, 0, 1'b0);
        chk({rd, u_tdw_mem_model.mem[67]}, {32'h8, m_fi | 32'h5});
        // reset in mid-walk: bus master and stream drop, status clears
        go(32'h120);
        repeat (3) @(posedge clock);
        rst_b <= 1'b0;
        @(posedge clock);
        chk({mem_req, tx_valid, tx_pkt_len}, 64'h0);
        rst_b <= 1'b1;
        apb(1'b0, `TDW_REG_STATUS, 32'h0);
        chk(rd, 64'h0);
        tally_and_finish;
    end
endmodule
